/* File: pkg/irq_resolver_pkg.sv */
// shared constants for the interrupt priority resolver
package irq_resolver_pkg;
    // polling positions: index 0 is nmi, then 1..14 in polling order
    localparam int NUM_SRC = 15;
    localparam int SRC_W = 4;
    localparam int LVL_W = 2;
    localparam int POS_NMI = 0;
    localparam int POS_EXT0 = 1;
    localparam int POS_TIMER0 = 2;
    localparam int POS_EXT1 = 3;
    localparam int POS_TIMER1 = 4;
    localparam int POS_UART = 5;
    localparam int POS_T2CAP_CAN_LIN = 6;
    localparam int POS_ADC_CAN = 7;
    localparam int POS_SYNC_SERIAL = 8;
    localparam int POS_EXT2_GROUP = 9;
    localparam int POS_EXT3_6_CAN = 10;
    localparam int POS_CCU_NODE0 = 11;
    localparam int POS_CCU_NODE3 = 14;
    localparam logic [3:0] NO_SRC = 4'hF;
    // state encoding for the grant sequencer
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SERVICE = 2'b01
    } resolver_state_t;
endpackage

/* File: hw/priority_pick.sv */
// combinational pick of the winning source by level then polling order
`timescale 1ns/1ps
module priority_pick #(
    parameter int NUM_SRC = 15,
    parameter int SRC_W = 4,
    parameter int LVL_W = 2
) (
    input wire logic [NUM_SRC-1:0] req,
    input wire logic [NUM_SRC*LVL_W-1:0] level,
    output logic found,
    output logic [SRC_W-1:0] win_idx,
    output logic [LVL_W-1:0] win_lvl
);
    initial begin
        if (NUM_SRC > (1 << SRC_W) - 1) begin
            $error("priority_pick: index width too small");
        end
    end

    // chain from last polling position back to first, so earlier position wins ties
    logic [NUM_SRC:0] f_c;
    logic [SRC_W-1:0] i_c [NUM_SRC+1];
    logic [LVL_W-1:0] l_c [NUM_SRC+1];
    assign f_c[NUM_SRC] = 1'b0;
    assign i_c[NUM_SRC] = '0;
    assign l_c[NUM_SRC] = '0;

    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g++) begin : g_chain
            wire [LVL_W-1:0] lv = level[g*LVL_W +: LVL_W];
            // higher level wins; equal level goes to the earlier position
            wire take = req[g] && (!f_c[g+1] || lv >= l_c[g+1]); // see R02 see R03
            assign f_c[g] = f_c[g+1] | req[g];
            assign i_c[g] = take ? SRC_W'(g) : i_c[g+1];
            assign l_c[g] = take ? lv : l_c[g+1];
        end
    endgenerate

    assign found = f_c[0];
    assign win_idx = i_c[0];
    assign win_lvl = l_c[0];
endmodule // priority_pick

/* File: hw/interrupt_priority_resolver.sv */
// interrupt priority resolver: level plus polling order, preemption by higher level
// How it works
// R01 - preempt service only on strictly higher level
// R02 - highest level pending request granted first
// R03 - same level ties: earliest polling position wins
// R04 - order nmi, ext0, timer0, ext1, timer1, uart
// R05 - 6 timer2/can/lin, 7 adc/can, 8 serial
// R06 - 9 ext2, timer21, second uart, muldiv, cordic
// R07 - 10 ext3-6/can; 11-14 capture node pointers
// R08 - levels from config input; grant registered per cycle
`timescale 1ns/1ps
module interrupt_priority_resolver #(
    parameter int NUM_SRC = irq_resolver_pkg::NUM_SRC,
    parameter int LVL_W = irq_resolver_pkg::LVL_W
) (
    input wire logic clk,
    input wire logic arst_n,
    // request lines in polling order, bit 0 nmi up to bit 14 node pointer 3
    input wire logic [NUM_SRC-1:0] irq_req,
    // per-source level, nmi forced to the top level internally
    input wire logic [NUM_SRC*LVL_W-1:0] irq_level,
    input wire logic global_enable,
    // core side
    output logic grant_valid,
    output logic [irq_resolver_pkg::SRC_W-1:0] grant_src,
    output logic [LVL_W-1:0] grant_level,
    output logic preempt,
    input wire logic grant_ack,
    input wire logic service_done,
    output logic [LVL_W-1:0] active_level,
    output logic [LVL_W:0] nest_depth
);
    localparam int SRC_W = irq_resolver_pkg::SRC_W;
    localparam int DEPTH = 1 << LVL_W;

    initial begin
        if (NUM_SRC != irq_resolver_pkg::NUM_SRC) begin
            $error("interrupt_priority_resolver: source count fixed by polling table");
        end
        if (LVL_W < 1) begin
            $error("interrupt_priority_resolver: level width must be at least 1");
        end
        if (SRC_W < $clog2(NUM_SRC + 1)) begin
            $error("interrupt_priority_resolver: index width too small for sources");
        end
        if (irq_resolver_pkg::POS_CCU_NODE3 != NUM_SRC - 1) begin
            $error("interrupt_priority_resolver: polling table does not end at last source");
        end
    end

    // nmi always carries the top level; others come from configuration
    logic [NUM_SRC*LVL_W-1:0] eff_level;
    assign eff_level = {irq_level[NUM_SRC*LVL_W-1:LVL_W], {LVL_W{1'b1}}}; // see R08 see R04

    // request lines named by polling position
    wire req_nmi = irq_req[irq_resolver_pkg::POS_NMI]; // see R04
    wire req_ext0 = irq_req[irq_resolver_pkg::POS_EXT0]; // see R04
    wire req_timer0 = irq_req[irq_resolver_pkg::POS_TIMER0]; // see R04
    wire req_ext1 = irq_req[irq_resolver_pkg::POS_EXT1]; // see R04
    wire req_timer1 = irq_req[irq_resolver_pkg::POS_TIMER1]; // see R04
    wire req_uart = irq_req[irq_resolver_pkg::POS_UART]; // see R04
    wire req_timer2_group = irq_req[irq_resolver_pkg::POS_T2CAP_CAN_LIN]; // see R05
    wire req_adc_group = irq_req[irq_resolver_pkg::POS_ADC_CAN]; // see R05
    wire req_serial = irq_req[irq_resolver_pkg::POS_SYNC_SERIAL]; // see R05
    wire req_ext2_group = irq_req[irq_resolver_pkg::POS_EXT2_GROUP]; // see R06
    wire req_ext3_group = irq_req[irq_resolver_pkg::POS_EXT3_6_CAN]; // see R07
    wire [3:0] req_node = irq_req[irq_resolver_pkg::POS_CCU_NODE3:irq_resolver_pkg::POS_CCU_NODE0];

    // requests packed back in polling order, earliest position in bit 0
    logic [NUM_SRC-1:0] ordered_req;
    assign ordered_req = {req_node, req_ext3_group, req_ext2_group, req_serial, req_adc_group,
        req_timer2_group, req_uart, req_timer1, req_ext1, req_timer0, req_ext0, req_nmi};

    // nmi ignores the global enable
    logic [NUM_SRC-1:0] live_req;
    assign live_req = {ordered_req[NUM_SRC-1:1] & {(NUM_SRC-1){global_enable}}, ordered_req[0]};

    logic found;
    logic [SRC_W-1:0] win_idx;
    logic [LVL_W-1:0] win_lvl;
    // index equals polling position, so tables R04 to R07 map straight to bits
    priority_pick #(
        .NUM_SRC(NUM_SRC),
        .SRC_W(SRC_W),
        .LVL_W(LVL_W)
    ) priority_pick_i (
        .req(live_req),
        .level(eff_level),
        .found(found),
        .win_idx(win_idx),
        .win_lvl(win_lvl)
    ); // see R04 see R05 see R06 see R07

    // stack of levels in service; one entry per level is enough as each push is higher
    logic [LVL_W-1:0] stack_r [DEPTH];
    logic [LVL_W:0] depth_r;
    logic [LVL_W:0] depth_nxt;
    logic in_service;
    logic [LVL_W-1:0] cur_lvl;
    irq_resolver_pkg::resolver_state_t state_r;
    irq_resolver_pkg::resolver_state_t state_nxt;
    logic [LVL_W-1:0] top_idx;
    assign in_service = (state_r == irq_resolver_pkg::ST_SERVICE);
    assign top_idx = depth_r[LVL_W-1:0] - LVL_W'(1);
    assign cur_lvl = in_service ? stack_r[top_idx] : '0;

    // idle: any request; busy: only strictly higher level may go through
    logic eligible;
    assign eligible = found && (!in_service || win_lvl > cur_lvl); // see R01

    logic accept;
    logic done_ok;
    assign accept = grant_valid && grant_ack;
    assign done_ok = service_done && in_service;

    always_comb begin
        depth_nxt = depth_r;
        if (done_ok && !accept) begin
            depth_nxt = depth_r - (LVL_W+1)'(1);
        end else if (accept && !done_ok) begin
            depth_nxt = depth_r + (LVL_W+1)'(1);
        end
    end

    logic [LVL_W:0] push_slot;
    assign push_slot = done_ok ? depth_r - (LVL_W+1)'(1) : depth_r;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            depth_r <= '0;
        end else begin
            depth_r <= depth_nxt;
        end
    end

    // service state follows whether any level is still on the stack
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            irq_resolver_pkg::ST_IDLE: begin
                if (depth_nxt != '0) begin
                    state_nxt = irq_resolver_pkg::ST_SERVICE;
                end
            end
            irq_resolver_pkg::ST_SERVICE: begin
                if (depth_nxt == '0) begin
                    state_nxt = irq_resolver_pkg::ST_IDLE;
                end
            end
            default: begin
                state_nxt = irq_resolver_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= irq_resolver_pkg::ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    genvar s;
    generate
        for (s = 0; s < DEPTH; s++) begin : g_stack
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    stack_r[s] <= '0;
                end else if (accept && push_slot == (LVL_W+1)'(s)) begin
                    stack_r[s] <= grant_level;
                end
            end
        end
    endgenerate

    // offer registered once per cycle; withdrawn on accept to avoid double grant
    logic gv_nxt;
    assign gv_nxt = eligible && !accept && !done_ok;

    // offer strobe
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            grant_valid <= 1'b0;
        end else begin
            grant_valid <= gv_nxt; // see R08
        end
    end

    // winner index, held while no offer stands
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            grant_src <= irq_resolver_pkg::NO_SRC;
        end else if (gv_nxt) begin
            grant_src <= win_idx; // see R02 see R03
        end
    end

    // winner level, pushed on the stack at accept
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            grant_level <= '0;
        end else if (gv_nxt) begin
            grant_level <= win_lvl;
        end
    end

    // offer would nest inside a running service
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            preempt <= 1'b0;
        end else if (gv_nxt) begin
            preempt <= in_service; // see R01
        end
    end

    assign active_level = cur_lvl;
    assign nest_depth = depth_r;
endmodule // interrupt_priority_resolver

/* File: verif/interrupt_priority_resolver_monitor.sv */
// checker for the interrupt priority resolver
`timescale 1ns/1ps
module interrupt_priority_resolver_monitor (
    input wire logic clk, arst_n, grant_valid, preempt, grant_ack, service_done,
    input wire logic [14:0] irq_req,
    input wire logic [3:0] grant_src,
    input wire logic [1:0] grant_level, active_level,
    input wire logic [2:0] nest_depth
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    wire acc = grant_valid && grant_ack;
    sequence s_take; acc && !service_done; endsequence
    sequence s_end; service_done && !acc; endsequence
    property p_src; grant_valid |-> (($past(irq_req) >> grant_src) & 15'h1) != 15'h0; endproperty
    a_src: assert property (p_src) else $error("grant of idle source");
    property p_none; !$past(|irq_req) |-> !grant_valid; endproperty
    a_none: assert property (p_none) else $error("grant without request");
    property p_drop; acc |=> !grant_valid; endproperty
    a_drop: assert property (p_drop) else $error("offer kept after accept");
    property p_pre; grant_valid && nest_depth != 3'h0 |-> preempt && grant_level > active_level;
    endproperty
    a_pre: assert property (p_pre) else $error("preempt not higher");
    property p_idle; grant_valid && nest_depth == 3'h0 |-> !preempt; endproperty
    a_idle: assert property (p_idle) else $error("preempt while idle");
    property p_nest; s_take |=> nest_depth == $past(nest_depth) + 3'h1; endproperty
    a_nest: assert property (p_nest) else $error("depth not raised");
    property p_end; s_end ##0 nest_depth != 3'h0 |=> nest_depth == $past(nest_depth) - 3'h1;
    endproperty
    a_end: assert property (p_end) else $error("depth not lowered");
    property p_nmi; $past(irq_req[0]) && grant_valid && nest_depth == 3'h0 |-> grant_src == 4'h0;
    endproperty
    a_nmi: assert property (p_nmi) else $error("nmi not first");
endmodule // interrupt_priority_resolver_monitor

/* File: verif/core_model.sv */
// core side model: accepts an offer after a set delay
`timescale 1ns/1ps
module core_model (
    input wire logic clk, arst_n, grant_valid, ack_en,
    input wire logic [3:0] dly,
    output logic grant_ack
);
    logic [3:0] wait_r;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) wait_r <= 4'h0;
        else wait_r <= (grant_valid && ack_en && !grant_ack) ? wait_r + 4'h1 : 4'h0;
    end
    assign grant_ack = grant_valid && ack_en && wait_r >= dly;
endmodule // core_model

/* File: verif/interrupt_priority_resolver_tb.sv */
// testbench for the interrupt priority resolver
`timescale 1ns/1ps
module interrupt_priority_resolver_tb;
    logic clk = 1'h0, arst_n = 1'h0, global_enable = 1'h1, service_done = 1'h0, ack_en = 1'h0;
    logic [14:0] irq_req = 15'h0;
    logic [29:0] irq_level = 30'h0;
    logic [3:0] dly = 4'h0, grant_src;
    logic grant_valid, preempt, grant_ack;
    logic [1:0] grant_level, active_level;
    logic [2:0] nest_depth;
    int error_cnt = 0, checks_done = 0;
    interrupt_priority_resolver interrupt_priority_resolver_i (.clk, .arst_n, .irq_req,
        .irq_level, .global_enable, .grant_valid, .grant_src, .grant_level, .preempt,
        .grant_ack, .service_done, .active_level, .nest_depth);
    core_model core_model_i (.clk, .arst_n, .grant_valid, .ack_en, .dly, .grant_ack);
    initial forever #20 clk = ~clk;
    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic offer(logic [3:0] src, logic [1:0] lvl, logic pre);
        int n;
        n = 0;
        while (grant_valid !== 1'h1) begin
            @(posedge clk);
            #1;
            if (++n > 20) begin
                error_cnt++;
                conclude();
            end
        end
        check("src", grant_src, src);
        check("level", grant_level, lvl);
        check("preempt", preempt, pre);
        @(posedge clk) ack_en <= 1'h1;
        n = 0;
        do begin @(negedge clk); n++; end while (!(grant_valid && grant_ack) && n < 10);
        check("accept", grant_valid & grant_ack, 1'h1);
        @(posedge clk) ack_en <= 1'h0;
        irq_req[src] <= 1'h0;
    endtask
    task automatic done();
        @(posedge clk) service_done <= 1'h1;
        @(posedge clk) service_done <= 1'h0;
    endtask
    task automatic hold(int c);
        repeat (c) @(posedge clk);
        #1 check("hold", grant_valid, 1'h0);
    endtask
    task automatic t_order();
        @(posedge clk) irq_level <= {15{2'h1}};
        irq_req <= 15'h7FFF;
        for (int p = 0; p < 15; p++) begin
            offer(p, (p == 0) ? 2'h3 : 2'h1, 1'h0);
            hold(3);
            done();
        end
    endtask
    task automatic t_level();
        @(posedge clk) irq_level <= 30'h20000004;
        irq_req <= 15'h4002;
        offer(4'hE, 2'h2, 1'h0);
        done();
        offer(4'h1, 2'h1, 1'h0);
        done();
    endtask
    task automatic t_enable();
        @(posedge clk) global_enable <= 1'h0;
        irq_req <= 15'h0005;
        offer(4'h0, 2'h3, 1'h0);
        done();
        hold(3);
        @(posedge clk) global_enable <= 1'h1;
        offer(4'h2, 2'h0, 1'h0);
        done();
    endtask
    task automatic t_preempt();
        @(posedge clk) irq_level <= 30'h00080440;
        dly <= 4'h3;
        irq_req[5] <= 1'h1;
        offer(4'h5, 2'h1, 1'h0);
        @(posedge clk) irq_req[3] <= 1'h1;
        hold(4);
        @(posedge clk) irq_req[9] <= 1'h1;
        offer(4'h9, 2'h2, 1'h1);
        #1 check("depth", nest_depth, 3'h2);
        check("active", active_level, 2'h2);
        done();
        hold(3);
        done();
        offer(4'h3, 2'h1, 1'h0);
        done();
    endtask
    initial begin
        repeat (10) @(posedge clk);
        arst_n <= 1'h1;
        #1 check("reset src", grant_src, 4'hF);
        check("reset depth", nest_depth, 3'h0);
        t_order();
        t_level();
        t_preempt();
        t_enable();
        conclude();
    end
endmodule // interrupt_priority_resolver_tb
bind interrupt_priority_resolver interrupt_priority_resolver_monitor
    interrupt_priority_resolver_monitor_i (.clk, .arst_n, .grant_valid, .preempt, .grant_ack,
    .service_done, .irq_req, .grant_src, .grant_level, .active_level, .nest_depth);
